// [hdl/cct_pkg.sv]
package cct_pkg;
    // Register indices; the byte address on the bus is four times the index.
    localparam logic [7:0] IDX_CC_SELECT   = 8'h80;
    localparam logic [7:0] IDX_COUNT       = 8'h84;
    localparam logic [7:0] IDX_SYS_CTRL    = 8'h86;
    localparam logic [7:0] IDX_ACT_HI      = 8'h88;
    localparam logic [7:0] IDX_ACT_LO      = 8'h89;
    localparam logic [7:0] IDX_EDGE_HI     = 8'h8a;
    localparam logic [7:0] IDX_EDGE_LO     = 8'h8b;
    localparam logic [7:0] IDX_CHAN_MASK   = 8'h8c;
    localparam logic [7:0] IDX_MISC_MASK   = 8'h8d;
    localparam logic [7:0] IDX_CHAN_FLAGS  = 8'h8e;
    localparam logic [7:0] IDX_OVF_FLAGS   = 8'h8f;
    localparam logic [7:0] IDX_CHAN0       = 8'h90;
    localparam logic [7:0] IDX_ACC_CTRL    = 8'ha0;
    localparam logic [7:0] IDX_ACC_FLAGS   = 8'ha1;
    localparam logic [7:0] IDX_ACC_COUNT   = 8'ha2;
    localparam int         NUM_CHAN        = 8;
    localparam int         MATCH_CHAN      = 7;

    // Field positions.
    localparam int BIT_TIMER_ON     = 7;
    localparam int BIT_HALT_WAIT    = 6;
    localparam int BIT_HALT_DEBUG   = 5;
    localparam int BIT_FAST_CLEAR   = 4;
    localparam int BIT_OVF_IRQ_EN   = 7;
    localparam int BIT_PULLUP       = 5;
    localparam int BIT_DRIVE_RED    = 4;
    localparam int BIT_CNT_RESET    = 3;
    localparam int BIT_OVF_FLAG     = 7;
    localparam int BIT_ACC_ON       = 6;
    localparam int BIT_ACC_GATED    = 5;
    localparam int BIT_ACC_WRAP     = 1;
    localparam int BIT_ACC_EDGE     = 0;

    // Prescaler and counter limits and values after reset.
    localparam logic [2:0]  PSC_MAX_SEL  = 3'h5;
    localparam logic [5:0]  PSC_DIV64    = 6'h3f;
    localparam logic [15:0] CNT_ALL_ONES = 16'hffff;
    localparam logic [15:0] RST_WORD     = 16'h0000;
    localparam logic [7:0]  RST_BYTE     = 8'h00;
    localparam logic [5:0]  RST_PSC      = 6'h00;
    localparam logic [31:0] RST_RDATA    = 32'h0000_0000;
endpackage

// [hdl/cct_timer.sv]
// Our own choice: the APB interface to the registers.
`timescale 1ns/100ps
module cct_timer
    import cct_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [9:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        specialMode,
    input  wire logic        waitMode,
    input  wire logic        debugMode,
    input  wire logic [7:0]  timerIn,
    output logic [7:0]       timerOut,
    output logic [7:0]       timerOe,
    output logic             pullupEn,
    output logic             driveReduce,
    output logic [7:0]       irqChannel,
    output logic             irqOverflow,
    output logic             irqAccWrap,
    output logic             irqAccEdge,
    output logic             div64Tick
);
    logic [31:0] prdata_ff;
    logic [7:0]  ccSelect_ff;
    logic [7:0]  sysCtrl_ff;
    logic [15:0] action_ff;
    logic [15:0] edgeSel_ff;
    logic [7:0]  chanMask_ff;
    logic [7:0]  miscMask_ff;
    logic [7:0]  accCtrl_ff;
    logic [15:0] count_ff;
    logic [5:0]  psc_ff;
    logic [2:0]  pscSel_ff;
    logic [7:0]  chanFlag_ff;
    logic        ovfFlag_ff;
    logic [15:0] accCount_ff;
    logic        accWrap_ff;
    logic        accEdge_ff;
    logic [7:0]  prevIn_ff;
    logic [7:0]  pinLevel_ff;
    logic [15:0] chanVal_ff [NUM_CHAN];
    logic [7:0]  idx;
    logic        mapped;
    logic        wrEn;
    logic        rdEn;
    logic        accessEn;
    logic        active;
    logic        tick;
    logic [5:0]  pscMask;
    logic [7:0]  matchHit;
    logic [7:0]  capHit;
    logic        cntReset;
    logic        ovfSet;
    logic        fastClear;
    logic        accEvent;
    logic        accEdgeSet;
    logic [31:0] rdMux;

    // Bus decode; the slave never inserts wait states.
    assign idx      = paddr[9:2];
    assign accessEn = psel & penable;
    assign wrEn     = accessEn & pwrite;
    assign rdEn     = accessEn & ~pwrite;
    assign pready   = 1'b1;
    assign mapped   = (idx == IDX_CC_SELECT) || (idx == IDX_COUNT)
                   || (idx >= IDX_SYS_CTRL && idx <= IDX_MISC_MASK)
                   || (idx >= IDX_CHAN_FLAGS && idx <= IDX_CHAN0 + 8'h07)
                   || (idx >= IDX_ACC_CTRL && idx <= IDX_ACC_COUNT);
    assign pslverr  = accessEn & ~mapped;
    assign prdata   = prdata_ff;
    assign fastClear = sysCtrl_ff[BIT_FAST_CLEAR];

    // Timer runs only when on and not held by a wait or debug halt.
    assign active = sysCtrl_ff[BIT_TIMER_ON]
                 & ~(sysCtrl_ff[BIT_HALT_WAIT] & waitMode)
                 & ~(sysCtrl_ff[BIT_HALT_DEBUG] & debugMode);

    // Stage mask gives division by two to the power of the applied code.
    assign pscMask   = 6'((7'h01 << pscSel_ff) - 7'h01);
    assign tick      = active & ((psc_ff & pscMask) == pscMask);
    assign div64Tick = active & (psc_ff == PSC_DIV64);
    assign pullupEn    = miscMask_ff[BIT_PULLUP];
    assign driveReduce = miscMask_ff[BIT_DRIVE_RED];

    // Channel and overflow requests follow flag and enable level; accumulator requests follow the flag alone.
    assign irqChannel  = chanFlag_ff & chanMask_ff;
    assign irqOverflow = ovfFlag_ff & miscMask_ff[BIT_OVF_IRQ_EN];
    assign irqAccWrap  = accWrap_ff;
    assign irqAccEdge  = accEdge_ff;

    // Channel 7 match resets the count instead of letting it wrap.
    assign cntReset = miscMask_ff[BIT_CNT_RESET] & matchHit[MATCH_CHAN];
    assign ovfSet   = tick & (count_ff == CNT_ALL_ONES) & ~cntReset;

    // Read data is registered in the setup phase, ready in the access phase.
    always_comb begin
        rdMux = RST_RDATA;
        unique case (idx)
            IDX_CC_SELECT:  rdMux[7:0]  = ccSelect_ff;
            IDX_COUNT:      rdMux[15:0] = count_ff;
            IDX_SYS_CTRL:   rdMux[7:0]  = sysCtrl_ff;
            IDX_ACT_HI:     rdMux[7:0]  = action_ff[15:8];
            IDX_ACT_LO:     rdMux[7:0]  = action_ff[7:0];
            IDX_EDGE_HI:    rdMux[7:0]  = edgeSel_ff[15:8];
            IDX_EDGE_LO:    rdMux[7:0]  = edgeSel_ff[7:0];
            IDX_CHAN_MASK:  rdMux[7:0]  = chanMask_ff;
            IDX_MISC_MASK:  rdMux[7:0]  = miscMask_ff;
            IDX_CHAN_FLAGS: rdMux[7:0]  = chanFlag_ff;
            IDX_OVF_FLAGS:  rdMux[BIT_OVF_FLAG] = ovfFlag_ff;
            IDX_ACC_CTRL:   rdMux[7:0]  = accCtrl_ff;
            IDX_ACC_FLAGS:  rdMux[1:0]  = {accWrap_ff, accEdge_ff};
            IDX_ACC_COUNT:  rdMux[15:0] = accCount_ff;
            default: begin
                if (idx >= IDX_CHAN0 && idx <= IDX_CHAN0 + 8'h07) begin
                    rdMux[15:0] = chanVal_ff[idx[2:0]];
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prdata_ff <= RST_RDATA;
        end else if (psel && !penable && !pwrite) begin
            prdata_ff <= rdMux;
        end
    end

    // Plain control registers, writable at any time.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ccSelect_ff <= RST_BYTE;
            sysCtrl_ff  <= RST_BYTE;
            action_ff   <= RST_WORD;
            edgeSel_ff  <= RST_WORD;
            chanMask_ff <= RST_BYTE;
            miscMask_ff <= RST_BYTE;
            accCtrl_ff  <= RST_BYTE;
        end else if (wrEn) begin
            unique case (idx)
                IDX_CC_SELECT: ccSelect_ff <= pwdata[7:0];
                IDX_SYS_CTRL:  sysCtrl_ff  <= pwdata[7:0];
                IDX_ACT_HI:    action_ff[15:8]  <= pwdata[7:0];
                IDX_ACT_LO:    action_ff[7:0]   <= pwdata[7:0];
                IDX_EDGE_HI:   edgeSel_ff[15:8] <= pwdata[7:0];
                IDX_EDGE_LO:   edgeSel_ff[7:0]  <= pwdata[7:0];
                IDX_CHAN_MASK: chanMask_ff <= pwdata[7:0];
                IDX_MISC_MASK: miscMask_ff <= pwdata[7:0];
                IDX_ACC_CTRL:  accCtrl_ff  <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // Prescaler runs while active; a new code waits for all stages zero so
    // the first period after a change is never a truncated one.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            psc_ff    <= RST_PSC;
            pscSel_ff <= 3'h0;
        end else if (active) begin
            psc_ff <= psc_ff + 6'h01;
            if (psc_ff == RST_PSC) begin
                pscSel_ff <= (miscMask_ff[2:0] > PSC_MAX_SEL) ?
                             PSC_MAX_SEL : miscMask_ff[2:0];
            end
        end
    end

    // Counter; a special-mode write does not touch the prescaler, so the
    // next period may be a short one.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            count_ff <= RST_WORD;
        end else if (wrEn && idx == IDX_COUNT) begin
            if (specialMode) begin
                count_ff <= pwdata[15:0];
            end
        end else if (tick) begin
            count_ff <= cntReset ? RST_WORD : count_ff + 16'h0001;
        end
    end

    // Overflow flag: hardware set wins over any clear in the same cycle.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ovfFlag_ff <= 1'b0;
        end else if (ovfSet) begin
            ovfFlag_ff <= 1'b1;
        end else if (wrEn && idx == IDX_OVF_FLAGS
                     && pwdata[BIT_OVF_FLAG]) begin
            ovfFlag_ff <= 1'b0;
        end else if (accessEn && fastClear && idx == IDX_COUNT) begin
            ovfFlag_ff <= 1'b0;
        end
    end

    // Per-channel capture, compare, flag and pin logic.
    generate
        for (genvar i = 0; i < NUM_CHAN; i++) begin : g_chan
            logic isCmp;
            logic rise;
            logic fall;
            logic chanWr;
            logic flagClr;
            logic [1:0] act;
            logic [1:0] edg;
            assign isCmp  = ccSelect_ff[i];
            assign act    = action_ff[2*i+1 -: 2];
            assign edg    = edgeSel_ff[2*i+1 -: 2];
            assign rise   = timerIn[i] & ~prevIn_ff[i];
            assign fall   = ~timerIn[i] & prevIn_ff[i];
            assign chanWr = wrEn && idx == IDX_CHAN0 + 8'(i);
            assign matchHit[i] = isCmp & tick
                               & (count_ff == chanVal_ff[i]);
            assign capHit[i] = ~isCmp & ((edg[0] & rise)
                             | (edg[1] & fall));
            assign flagClr = (wrEn && idx == IDX_CHAN_FLAGS && pwdata[i])
                || (fastClear && ((chanWr && isCmp)
                || (rdEn && idx == IDX_CHAN0 + 8'(i) && !isCmp)));
            assign timerOe[i]  = |act;
            assign timerOut[i] = pinLevel_ff[i];

            // Capture latches the count; writes only land in compare mode.
            always_ff @(posedge clk_sys or posedge rst) begin
                if (rst) begin
                    chanVal_ff[i] <= RST_WORD;
                end else if (capHit[i]) begin
                    chanVal_ff[i] <= count_ff;
                end else if (chanWr && isCmp) begin
                    chanVal_ff[i] <= pwdata[15:0];
                end
            end

            // Set by a match or capture, beating a clear in the same cycle.
            always_ff @(posedge clk_sys or posedge rst) begin
                if (rst) begin
                    chanFlag_ff[i] <= 1'b0;
                end else if (matchHit[i] || capHit[i]) begin
                    chanFlag_ff[i] <= 1'b1;
                end else if (flagClr) begin
                    chanFlag_ff[i] <= 1'b0;
                end
            end

            // Pin action on a match.
            always_ff @(posedge clk_sys or posedge rst) begin
                if (rst) begin
                    pinLevel_ff[i] <= 1'b0;
                end else if (matchHit[i]) begin
                    unique case (act)
                        2'b00: pinLevel_ff[i] <= pinLevel_ff[i];
                        2'b01: pinLevel_ff[i] <= ~pinLevel_ff[i];
                        2'b10: pinLevel_ff[i] <= 1'b0;
                        2'b11: pinLevel_ff[i] <= 1'b1;
                    endcase
                end
            end
        end
    endgenerate

    // Previous pin levels for edge detection.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prevIn_ff <= RST_BYTE;
        end else begin
            prevIn_ff <= timerIn;
        end
    end

    // Pulse accumulator on pin 7: event edges, or gated divide-by-64 ticks.
    assign accEvent = accCtrl_ff[BIT_ACC_ON] & (accCtrl_ff[BIT_ACC_GATED] ?
                      (div64Tick & timerIn[MATCH_CHAN])
                    : (timerIn[MATCH_CHAN] & ~prevIn_ff[MATCH_CHAN]));
    assign accEdgeSet = accCtrl_ff[BIT_ACC_ON] & (accCtrl_ff[BIT_ACC_GATED] ?
                      (~timerIn[MATCH_CHAN] & prevIn_ff[MATCH_CHAN])
                    : (timerIn[MATCH_CHAN] & ~prevIn_ff[MATCH_CHAN]));

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            accCount_ff <= RST_WORD;
        end else if (wrEn && idx == IDX_ACC_COUNT) begin
            accCount_ff <= pwdata[15:0];
        end else if (accEvent) begin
            accCount_ff <= accCount_ff + 16'h0001;
        end
    end

    // Accumulator flags; a set beats a clear in the same cycle.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            accWrap_ff <= 1'b0;
            accEdge_ff <= 1'b0;
        end else begin
            if (accEvent && accCount_ff == CNT_ALL_ONES
                && !(wrEn && idx == IDX_ACC_COUNT)) begin
                accWrap_ff <= 1'b1;
            end else if ((wrEn && idx == IDX_ACC_FLAGS && pwdata[BIT_ACC_WRAP])
                     || (accessEn && fastClear && idx == IDX_ACC_COUNT)) begin
                accWrap_ff <= 1'b0;
            end
            if (accEdgeSet) begin
                accEdge_ff <= 1'b1;
            end else if ((wrEn && idx == IDX_ACC_FLAGS && pwdata[BIT_ACC_EDGE])
                     || (accessEn && fastClear && idx == IDX_ACC_COUNT)) begin
                accEdge_ff <= 1'b0;
            end
        end
    end

    // Checks on the timing core.
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    property p_cnt_wr_ignored;
        wrEn && idx == IDX_COUNT && !specialMode && !tick |=> $stable(count_ff);
    endproperty
    a_cnt_wr_ignored: assert property (p_cnt_wr_ignored)
        else $error("counter changed by a normal-mode write");

    property p_halt_off;
        !sysCtrl_ff[BIT_TIMER_ON] && !wrEn [*2] |-> $stable(count_ff);
    endproperty
    a_halt_off: assert property (p_halt_off)
        else $error("counter moved while timer off");

    // The tick needs the timer on and cannot repeat on the next clock.
    property p_div64;
        div64Tick |-> sysCtrl_ff[BIT_TIMER_ON] ##1 !div64Tick;
    endproperty
    a_div64: assert property (p_div64)
        else $error("divide-by-64 tick while inactive");

    property p_wait;
        sysCtrl_ff[BIT_HALT_WAIT] && waitMode && !wrEn
            |=> $stable(count_ff) && $stable(psc_ff);
    endproperty
    a_wait: assert property (p_wait)
        else $error("timer ran during wait halt");

    property p_ovf_set;
        ovfSet |=> ovfFlag_ff && count_ff == RST_WORD;
    endproperty
    a_ovf_set: assert property (p_ovf_set)
        else $error("wrap did not set overflow flag");

    property p_cnt_reset;
        tick && cntReset && !(wrEn && idx == IDX_COUNT) |=> count_ff == RST_WORD
            && (!ovfFlag_ff || $past(ovfFlag_ff));
    endproperty
    a_cnt_reset: assert property (p_cnt_reset)
        else $error("channel 7 match did not reset counter");

    property p_psc_apply;
        $changed(pscSel_ff) |-> $past(psc_ff) == RST_PSC;
    endproperty
    a_psc_apply: assert property (p_psc_apply)
        else $error("prescale changed with stages not zero");

    property p_w1c;
        wrEn && idx == IDX_CHAN_FLAGS && pwdata[7:0] == 8'hff
            && (matchHit | capHit) == RST_BYTE |=> chanFlag_ff == RST_BYTE;
    endproperty
    a_w1c: assert property (p_w1c)
        else $error("write-one did not clear channel flags");

    property p_capture1;
        capHit[1] && !(wrEn && idx == IDX_COUNT)
            |=> chanVal_ff[1] == $past(count_ff) && chanFlag_ff[1];
    endproperty
    a_capture1: assert property (p_capture1)
        else $error("capture did not latch count");

    property p_ovf_irq;
        ovfSet && miscMask_ff[BIT_OVF_IRQ_EN] ##1 !$changed(miscMask_ff)
            |-> irqOverflow;
    endproperty
    a_ovf_irq: assert property (p_ovf_irq)
        else $error("overflow request missing");

    c_match: cover property (matchHit[0] ##1 timerOe[0]);
    c_capture: cover property (capHit[1]);
    c_reset7: cover property (tick && cntReset);
    c_fast_clear: cover property (fastClear && rdEn && idx == IDX_CHAN0 + 8'h01);
endmodule // cct_timer

// [bench/cct_pin_model.sv]
`timescale 1ns/100ps
// Far side of the timer pins: resolves each pin from every driver on it.
module cct_pin_model (
    input  wire logic       clk_sys,
    input  wire logic [7:0] timerOut,
    input  wire logic [7:0] timerOe,
    input  wire logic       pullupEn,
    input  wire logic [7:0] extDrive,
    input  wire logic [7:0] extLevel,
    output logic [7:0]      timerIn
);
    logic [7:0] floatLvl = 8'h55;

    // A floating pin changes every cycle, so a stale level never passes.
    always_ff @(posedge clk_sys) begin
        floatLvl <= ~floatLvl;
    end

    // The block's enable wins, then the bench, then the pull-up.
    assign timerIn = (timerOe & timerOut)
                   | (~timerOe & extDrive & extLevel)
                   | (~timerOe & ~extDrive & (pullupEn ? 8'hff : floatLvl));
endmodule // cct_pin_model

// [bench/test_capture_compare_timer.sv]
`timescale 1ns/100ps
module test_capture_compare_timer
    import cct_pkg::*;
;
    logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr;
    logic        specialMode, waitMode, debugMode, pullupEn, driveReduce;
    logic        irqOverflow, div64Tick, lastErr, irqAccWrap, irqAccEdge;
    logic [9:0]  paddr;
    logic [31:0] pwdata, prdata, r;
    logic [7:0]  timerIn, timerOut, timerOe, irqChannel, extLevel;
    int          mismatches = 0;
    int          nCompared = 0;
    int          nTick = 0;
    int          t;

    cct_timer uut (
        .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .specialMode(specialMode),
        .waitMode(waitMode), .debugMode(debugMode), .timerIn(timerIn),
        .timerOut(timerOut), .timerOe(timerOe), .pullupEn(pullupEn),
        .driveReduce(driveReduce), .irqChannel(irqChannel),
        .irqOverflow(irqOverflow), .irqAccWrap(irqAccWrap),
        .irqAccEdge(irqAccEdge),
        .div64Tick(div64Tick)
    );

    // Channels 1 and 7 are driven by the bench, channel 0 by the timer once its action is set; the rest float or pull up.
    cct_pin_model pins (
        .clk_sys(clk_sys), .timerOut(timerOut), .timerOe(timerOe),
        .pullupEn(pullupEn), .extDrive(8'h82), .extLevel(extLevel),
        .timerIn(timerIn)
    );

    // Clock at 10 MHz.
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // Counts prescaler divide-by-64 pulses.
    always @(posedge clk_sys) begin
        if (div64Tick === 1'b1) nTick <= nTick + 1;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] e);
        nCompared++;
        if (got !== e) begin
            mismatches++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, e);
        end
    endtask

    // Bus master: the request is held until pready is seen at an edge.
    task automatic apb(input logic [7:0] idx, input logic dirW,
                       input logic [31:0] wd, output logic [31:0] rdat);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= dirW;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rdat = prdata;
        lastErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic wrReg(input logic [7:0] idx, input logic [15:0] d);
        apb(idx, 1'b1, {16'h0000, d}, r);
    endtask

    task automatic rdReg(input logic [7:0] idx, input logic [15:0] e);
        apb(idx, 1'b0, 32'h0000_0000, r);
        chk(r, {16'h0000, e});
    endtask

    task automatic stop_test;
        if (mismatches == 0 && nCompared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Main sequence; the timer is stopped or halted whenever exact counts matter, except where a channel 7 match holds the count at zero.
    initial begin
        {rst, psel, penable, pwrite} <= 4'b1000;
        paddr <= 10'h000;
        pwdata <= 32'h0000_0000;
        {specialMode, waitMode, debugMode} <= 3'b000;
        extLevel <= 8'h00;
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        chk(32'(timerOe), 32'h0000_0000);
        apb(8'h00, 1'b0, 32'h0000_0000, r);
        chk({r[30:0], lastErr}, 32'h0000_0001);
        wrReg(IDX_COUNT, 16'h1234);
        rdReg(IDX_COUNT, 16'h0000);
        specialMode <= 1'b1;
        wrReg(IDX_COUNT, 16'h1234);
        repeat (20) @(posedge clk_sys);
        rdReg(IDX_COUNT, 16'h1234);
        wrReg(IDX_MISC_MASK, 16'h00b0);
        chk(32'({pullupEn, driveReduce}), 32'h0000_0003);
        wrReg(IDX_COUNT, 16'hfff8);
        wrReg(IDX_SYS_CTRL, 16'h0080);
        repeat (30) @(posedge clk_sys);
        rdReg(IDX_OVF_FLAGS, 16'h0080);
        chk(32'(irqOverflow), 32'h0000_0001);
        wrReg(IDX_MISC_MASK, 16'h0030);
        chk(32'(irqOverflow), 32'h0000_0000);
        wrReg(IDX_OVF_FLAGS, 16'h0000);
        rdReg(IDX_OVF_FLAGS, 16'h0080);
        wrReg(IDX_OVF_FLAGS, 16'h0080);
        rdReg(IDX_OVF_FLAGS, 16'h0000);
        // Wait mode, then debug mode, each with its halt bit set.
        for (int i = 0; i < 2; i++) begin
            waitMode <= (i == 0);
            debugMode <= (i == 1);
            wrReg(IDX_SYS_CTRL, (i == 0) ? 16'h00c0 : 16'h00a0);
            apb(IDX_COUNT, 1'b0, 32'h0000_0000, r);
            repeat (10) @(posedge clk_sys);
            rdReg(IDX_COUNT, r[15:0]);
        end
        {waitMode, debugMode} <= 2'b00;
        // The wait lets a new division settle before the count restarts.
        for (int p = 0; p < 6; p++) begin
            wrReg(IDX_MISC_MASK, 16'(p));
            repeat (70) @(posedge clk_sys);
            wrReg(IDX_COUNT, 16'h0000);
            repeat (256) @(posedge clk_sys);
            apb(IDX_COUNT, 1'b0, 32'h0000_0000, r);
            chk(32'(r >= (256 >> p) && r <= (260 >> p) + 1), 32'h0000_0001);
        end
        t = nTick;
        repeat (256) @(posedge clk_sys);
        chk(32'(nTick - t), 32'h0000_0004);
        wrReg(IDX_MISC_MASK, 16'h0000);
        repeat (70) @(posedge clk_sys);
        wrReg(IDX_SYS_CTRL, 16'h0000);
        t = nTick;
        repeat (200) @(posedge clk_sys);
        chk(32'(nTick - t), 32'h0000_0000);
        // Channel 0 compare: set, clear, then toggle back to high.
        wrReg(IDX_CC_SELECT, 16'h0001);
        wrReg(IDX_CHAN_MASK, 16'h0001);
        for (int k = 0; k < 3; k++) begin
            wrReg(IDX_ACT_LO, 16'(3 - k));
            chk(32'(timerOe[0]), 32'h0000_0001);
            wrReg(IDX_COUNT, 16'h0100);
            wrReg(IDX_CHAN0, 16'h0110);
            wrReg(IDX_CHAN_FLAGS, 16'h00ff);
            wrReg(IDX_SYS_CTRL, 16'h0080);
            repeat (30) @(posedge clk_sys);
            wrReg(IDX_SYS_CTRL, 16'h0000);
            chk(32'(timerOut[0]), 32'(k != 1));
            rdReg(IDX_CHAN_FLAGS, 16'h0001);
            chk(32'(irqChannel), 32'h0000_0001);
        end
        // Channel 1 captures rising edges only; its register is read-only.
        wrReg(IDX_EDGE_LO, 16'h0004);
        wrReg(IDX_COUNT, 16'h0200);
        wrReg(IDX_CHAN_FLAGS, 16'h00ff);
        extLevel <= 8'h02;
        repeat (4) @(posedge clk_sys);
        rdReg(IDX_CHAN0 + 8'h01, 16'h0200);
        rdReg(IDX_CHAN_FLAGS, 16'h0002);
        wrReg(IDX_COUNT, 16'h0300);
        wrReg(IDX_CHAN0 + 8'h01, 16'haaaa);
        extLevel <= 8'h00;
        repeat (4) @(posedge clk_sys);
        rdReg(IDX_CHAN0 + 8'h01, 16'h0200);
        wrReg(IDX_SYS_CTRL, 16'h0010);
        rdReg(IDX_CHAN0 + 8'h01, 16'h0200);
        rdReg(IDX_CHAN_FLAGS, 16'h0000);
        wrReg(IDX_COUNT, 16'hfff8);
        wrReg(IDX_SYS_CTRL, 16'h0090);
        repeat (30) @(posedge clk_sys);
        rdReg(IDX_OVF_FLAGS, 16'h0080);
        apb(IDX_COUNT, 1'b0, 32'h0000_0000, r);
        rdReg(IDX_OVF_FLAGS, 16'h0000);
        // Channel 7 match restarts the count.
        wrReg(IDX_SYS_CTRL, 16'h0000);
        wrReg(IDX_CC_SELECT, 16'h0080);
        wrReg(IDX_CHAN0 + 8'h07, 16'h0000);
        wrReg(IDX_MISC_MASK, 16'h0008);
        wrReg(IDX_COUNT, 16'h0000);
        wrReg(IDX_SYS_CTRL, 16'h0080);
        repeat (20) @(posedge clk_sys);
        rdReg(IDX_COUNT, 16'h0000);
        wrReg(IDX_CHAN0 + 8'h07, 16'h0005);
        repeat (20) @(posedge clk_sys);
        apb(IDX_COUNT, 1'b0, 32'h0000_0000, r);
        chk(32'(r <= 32'h0000_0005), 32'h0000_0001);
        // Accumulator counts a pin 7 rising edge with the timer off.
        wrReg(IDX_SYS_CTRL, 16'h0010);
        wrReg(IDX_ACC_COUNT, 16'hffff);
        wrReg(IDX_ACC_CTRL, 16'h0040);
        extLevel <= 8'h80;
        repeat (4) @(posedge clk_sys);
        extLevel <= 8'h00;
        chk(32'({irqAccWrap, irqAccEdge}), 32'h0000_0003);
        rdReg(IDX_ACC_COUNT, 16'h0000);
        rdReg(IDX_ACC_FLAGS, 16'h0000);
        stop_test();
    end

    // The sequence needs about 3000 cycles; this cuts a hang short.
    initial begin
        repeat (20000) @(posedge clk_sys);
        mismatches++;
        stop_test();
    end
endmodule // test_capture_compare_timer
